//--- verilog/cfq_pkg.sv
// Package: register map, field positions and reset values of the FIFO flag block
package cfq_pkg;
    localparam int          CFQ_AW             = 4;
    localparam logic [3:0]  CFQ_OFS_MSG_CTRL   = 4'h0;
    localparam logic [3:0]  CFQ_OFS_MSG_STATUS = 4'h4;
    localparam logic [3:0]  CFQ_OFS_EVT_CTRL   = 4'h8;
    localparam logic [3:0]  CFQ_OFS_EVT_STATUS = 4'hc;
    localparam logic [2:0]  CFQ_MODE_CONFIG    = 3'h4;
    // Message FIFO control (own layout)
    localparam int CFQ_MC_DEPTH_LSB = 24;
    localparam int CFQ_MC_DIR       = 7;
    // Status / control bit positions
    localparam int CFQ_ST_NSNE   = 0;
    localparam int CFQ_ST_HALF   = 1;
    localparam int CFQ_ST_EF     = 2;
    localparam int CFQ_ST_OVF    = 3;
    localparam int CFQ_ST_ERR    = 5;
    localparam int CFQ_ST_LARB   = 6;
    localparam int CFQ_ST_ABT    = 7;
    localparam int CFQ_ST_IDX    = 8;
    localparam int CFQ_EC_DEPTH  = 24;
    localparam int CFQ_EC_RESET  = 10;
    localparam int CFQ_EC_TAIL   = 8;
    localparam int CFQ_EC_TSEN   = 5;
    localparam logic [4:0] CFQ_DEPTH_RST = 5'h00;
    localparam logic [3:0] CFQ_IE_RST    = 4'h0;
    typedef enum logic [1:0] {
        CFQ_OUT_NONE  = 2'b00,
        CFQ_OUT_DONE  = 2'b01,
        CFQ_OUT_ABORT = 2'b10
    } cfq_outcome_type;
endpackage

//--- verilog/cfq_flag_if.sv
// Interface: occupancy and derived flags between the top and the flag unit
interface cfq_flag_if;
    logic [5:0] count;
    logic [4:0] depth_code;
    logic       is_tx;
    logic       ef_flag;
    logic       half_flag;
    logic       ns_flag;
    logic       full;
    modport calc (input count, depth_code, is_tx, output ef_flag, half_flag, ns_flag, full);
    modport user (output count, depth_code, is_tx, input ef_flag, half_flag, ns_flag, full);
endinterface

//--- verilog/cfq_flag_calc.sv
// Flag unit: direction-dependent occupancy flags for one FIFO
module cfq_flag_calc (
    cfq_flag_if.calc f
);
    logic [5:0] depth;
    logic [6:0] twice;
    always_comb begin
        // RL21 depth from code
        depth = {1'b0, f.depth_code} + 6'h01;
        twice = {f.count, 1'b0};
        f.full = (f.count >= depth);
        if (f.is_tx) begin
            // RL1 empty flag
            f.ef_flag = (f.count == 6'h00);
            // RL3 at or below half
            f.half_flag = (twice <= {1'b0, depth});
            // RL5 space remains
            f.ns_flag = !f.full;
        end else begin
            // RL2 full flag
            f.ef_flag = f.full;
            // RL4 at or above half
            f.half_flag = (twice >= {1'b0, depth});
            // RL6 content present
            f.ns_flag = (f.count != 6'h00);
        end
    end
endmodule

//--- verilog/cfq_top.sv
// Top: message FIFO status and event FIFO control/status behind classic Wishbone
// How it works
// RL1 - Transmit FIFO: empty/full flag set while nothing queued.
// RL2 - Receive FIFO: empty/full flag set only when completely full.
// RL3 - Transmit FIFO: half flag when occupancy at or below half depth.
// RL4 - Receive FIFO: half flag when occupancy at or above half depth.
// RL5 - Transmit FIFO: space flag high while a free slot remains.
// RL6 - Receive FIFO: content flag high while a message is stored.
// RL7 - Slot index is zero-based, from zero to depth minus one.
// RL8 - Outcome bits clear on status read and on queue reset.
// RL9 - Outcome bits change only on completion, abort or FIFO reset; the code also clears them on status read and queue reset.
// RL10 - Event depth field bits 28-24, code n gives n+1 messages.
// RL11 - Event reset bit 10 resets FIFO, hardware clears it when done.
// RL12 - Tail advance bit 8 moves tail by one, self-clearing.
// RL13 - Timestamp enable bit 5 selects timestamped event elements.
// RL14 - Event interrupt enables: overflow 3, full 2, half 1, nonempty 0.
// RL15 - Depth and timestamp enable writable only in configuration mode.
// RL16 - Unimplemented event control bits read zero.
// RL17 - Event status: overflow, full, at least half, not empty.
// RL18 - Overflow flag: hardware sets, reset or software clears.
// RL19 - Direction select one means transmit, zero receive.
// RL20 - Interrupt request when flag and its enable both set.
// RL21 - Half thresholds use depth code plus one.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
module cfq_top
    import cfq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic [2:0]  operating_mode_field_i,
    input  wire logic        msg_push_i,
    input  wire logic        msg_pop_i,
    input  wire logic [1:0]  msg_outcome_i,
    input  wire logic        msg_arb_lost_i,
    input  wire logic        msg_bus_err_i,
    input  wire logic        msg_reset_i,
    input  wire logic        transmit_queue_reset_i,
    input  wire logic        event_push_i,
    output logic             msg_irq_o,
    output logic             event_irq_o,
    output logic             event_timestamp_enable_o,
    output logic             event_tail_step_o,
    output logic [4:0]       event_tail_o,
    output logic [4:0]       msg_slot_index_o
);
    logic        req;
    logic        wr;
    logic        rd;
    logic        cfg_mode;
    logic [4:0]  msg_depth_code_r;
    logic        direction_select_r;
    logic [2:0]  msg_ie_r;
    logic [5:0]  msg_count_r;
    logic [4:0]  msg_head_r;
    logic        send_aborted_status_r;
    logic        arbitration_lost_status_r;
    logic        send_bus_error_status_r;
    logic [4:0]  event_depth_code_r;
    logic        event_timestamp_enable_r;
    logic [3:0]  event_ie_r;
    logic        queue_clear_request_r;
    logic [5:0]  event_count_r;
    logic [4:0]  event_tail_r;
    logic        event_overflow_flag_r;
    logic        tail_step_r;
    logic [31:0] msg_status;
    logic [31:0] event_ctrl;
    logic [31:0] event_status;
    logic [31:0] rd_nxt;
    logic [3:0]  event_flags;
    logic        event_push_ok;
    cfq_outcome_type outcome;

    cfq_flag_if mf();
    cfq_flag_if ef();

    cfq_flag_calc u_msg_flags (
        .f (mf)
    );
    cfq_flag_calc u_event_flags (
        .f (ef)
    );

    function automatic logic [4:0] cfq_wrap_inc(input logic [4:0] ptr, input logic [4:0] code);
        cfq_wrap_inc = (ptr == code) ? 5'h00 : ptr + 5'h01;
    endfunction

    assign req      = cyc_i && stb_i && !ack_o;
    assign wr       = req && we_i;
    assign rd       = req && !we_i;
    // RL15 configuration mode gate
    assign cfg_mode = (operating_mode_field_i == CFQ_MODE_CONFIG);
    assign outcome  = cfq_outcome_type'(msg_outcome_i);

    assign mf.count      = msg_count_r;
    assign mf.depth_code = msg_depth_code_r;
    // RL19 direction follows select
    assign mf.is_tx      = direction_select_r;
    assign ef.count      = event_count_r;
    assign ef.depth_code = event_depth_code_r;
    assign ef.is_tx      = 1'b0;

    // RL17 event status meanings
    assign event_flags = {event_overflow_flag_r, ef.full, ef.half_flag, ef.ns_flag};
    assign event_push_ok = event_push_i && !ef.full && !queue_clear_request_r;

    always_comb begin
        msg_status = 32'h0000_0000;
        msg_status[CFQ_ST_NSNE] = mf.ns_flag;
        msg_status[CFQ_ST_HALF] = mf.half_flag;
        msg_status[CFQ_ST_EF]   = mf.ef_flag;
        msg_status[CFQ_ST_ERR]  = send_bus_error_status_r;
        msg_status[CFQ_ST_LARB] = arbitration_lost_status_r;
        msg_status[CFQ_ST_ABT]  = send_aborted_status_r;
        msg_status[CFQ_ST_IDX +: 5] = msg_head_r;
        // RL16 unused bits stay zero
        event_ctrl = 32'h0000_0000;
        event_ctrl[CFQ_EC_DEPTH +: 5] = event_depth_code_r;
        event_ctrl[CFQ_EC_RESET]      = queue_clear_request_r;
        event_ctrl[CFQ_EC_TAIL]       = tail_step_r;
        event_ctrl[CFQ_EC_TSEN]       = event_timestamp_enable_r;
        event_ctrl[3:0]               = event_ie_r;
        event_status = {28'h000_0000, event_flags};
        case (adr_i)
            CFQ_OFS_MSG_CTRL: begin
                rd_nxt = 32'h0000_0000;
                rd_nxt[CFQ_MC_DEPTH_LSB +: 5] = msg_depth_code_r;
                rd_nxt[CFQ_MC_DIR]            = direction_select_r;
                rd_nxt[2:0]                   = msg_ie_r;
            end
            CFQ_OFS_MSG_STATUS: rd_nxt = msg_status;
            CFQ_OFS_EVT_CTRL:   rd_nxt = event_ctrl;
            CFQ_OFS_EVT_STATUS: rd_nxt = event_status;
            default:            rd_nxt = 32'h0000_0000;
        endcase
    end

    // Single-wait-state slave, unmapped addresses ack with zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= rd ? rd_nxt : 32'h0000_0000;
        end
    end

    // Message FIFO control; depth and direction are configuration-only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_depth_code_r   <= CFQ_DEPTH_RST;
            direction_select_r <= 1'b0;
            msg_ie_r           <= 3'h0;
        end else if (wr && adr_i == CFQ_OFS_MSG_CTRL) begin
            if (cfg_mode && sel_i[3]) msg_depth_code_r <= dat_i[CFQ_MC_DEPTH_LSB +: 5];
            if (cfg_mode && sel_i[0]) direction_select_r <= dat_i[CFQ_MC_DIR];
            if (sel_i[0]) msg_ie_r <= dat_i[2:0];
        end
    end

    // RL7 zero-based slot index wraps at depth
    always_ff @(posedge clk_i) begin
        if (rst_i || msg_reset_i) begin
            msg_count_r <= 6'h00;
            msg_head_r  <= 5'h00;
        end else begin
            if (msg_push_i && !mf.full && !(msg_pop_i && msg_count_r != 6'h00))
                msg_count_r <= msg_count_r + 6'h01;
            else if (msg_pop_i && msg_count_r != 6'h00 && !msg_push_i)
                msg_count_r <= msg_count_r - 6'h01;
            // Index moves only for a message actually taken or stored
            if (direction_select_r ? (msg_pop_i && msg_count_r != 6'h00) : (msg_push_i && !mf.full))
                msg_head_r <= cfq_wrap_inc(msg_head_r, msg_depth_code_r);
        end
    end

    // RL9 outcome bits move on completion, abort or FIFO reset
    always_ff @(posedge clk_i) begin
        if (rst_i || msg_reset_i) begin
            send_aborted_status_r     <= 1'b0;
            arbitration_lost_status_r <= 1'b0;
            send_bus_error_status_r   <= 1'b0;
        end else if (outcome == CFQ_OUT_DONE || outcome == CFQ_OUT_ABORT) begin
            send_aborted_status_r     <= (outcome == CFQ_OUT_ABORT);
            arbitration_lost_status_r <= msg_arb_lost_i;
            send_bus_error_status_r   <= msg_bus_err_i;
        // RL8 clear on read or queue reset
        end else if ((rd && adr_i == CFQ_OFS_MSG_STATUS) || transmit_queue_reset_i) begin
            send_aborted_status_r     <= 1'b0;
            arbitration_lost_status_r <= 1'b0;
            send_bus_error_status_r   <= 1'b0;
        end
    end

    // Event FIFO control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_depth_code_r       <= CFQ_DEPTH_RST;
            event_timestamp_enable_r <= 1'b0;
            event_ie_r               <= CFQ_IE_RST;
        end else if (wr && adr_i == CFQ_OFS_EVT_CTRL) begin
            // RL10 depth field
            if (cfg_mode && sel_i[3]) event_depth_code_r <= dat_i[CFQ_EC_DEPTH +: 5];
            // RL13 timestamp enable
            if (cfg_mode && sel_i[0]) event_timestamp_enable_r <= dat_i[CFQ_EC_TSEN];
            // RL14 interrupt enables
            if (sel_i[0]) event_ie_r <= dat_i[3:0];
        end
    end

    // RL11 reset request, cleared when FIFO emptied; reads one after reset
    always_ff @(posedge clk_i) begin
        if (rst_i)
            queue_clear_request_r <= 1'b1;
        else if (wr && adr_i == CFQ_OFS_EVT_CTRL && sel_i[1] && dat_i[CFQ_EC_RESET])
            queue_clear_request_r <= 1'b1;
        else if (queue_clear_request_r && event_count_r == 6'h00)
            queue_clear_request_r <= 1'b0;
    end

    // RL12 tail advance, one message per request
    always_ff @(posedge clk_i) begin
        if (rst_i)
            tail_step_r <= 1'b0;
        else
            tail_step_r <= wr && adr_i == CFQ_OFS_EVT_CTRL && sel_i[1] && dat_i[CFQ_EC_TAIL]
                           && event_count_r != 6'h00 && !queue_clear_request_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || queue_clear_request_r) begin
            event_count_r <= 6'h00;
            event_tail_r  <= 5'h00;
        end else begin
            if (event_push_ok && !tail_step_r)
                event_count_r <= event_count_r + 6'h01;
            else if (tail_step_r && !event_push_ok)
                event_count_r <= event_count_r - 6'h01;
            if (tail_step_r)
                event_tail_r <= cfq_wrap_inc(event_tail_r, event_depth_code_r);
        end
    end

    // RL18 overflow: set wins over software clear, FIFO reset clears
    always_ff @(posedge clk_i) begin
        if (rst_i || queue_clear_request_r)
            event_overflow_flag_r <= 1'b0;
        else if (event_push_i && ef.full)
            event_overflow_flag_r <= 1'b1;
        else if (wr && adr_i == CFQ_OFS_EVT_STATUS && sel_i[0] && !dat_i[CFQ_ST_OVF])
            event_overflow_flag_r <= 1'b0;
    end

    // RL20 interrupt requests
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_irq_o   <= 1'b0;
            event_irq_o <= 1'b0;
        end else begin
            msg_irq_o   <= |(msg_ie_r & msg_status[2:0]);
            event_irq_o <= |(event_ie_r & event_flags);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_timestamp_enable_o <= 1'b0;
            event_tail_step_o        <= 1'b0;
            event_tail_o             <= 5'h00;
            msg_slot_index_o         <= 5'h00;
        end else begin
            event_timestamp_enable_o <= event_timestamp_enable_r;
            event_tail_step_o        <= tail_step_r;
            event_tail_o             <= event_tail_r;
            msg_slot_index_o         <= msg_head_r;
        end
    end
endmodule

//--- bench/cfq_top_sva.sv
// Checker: bus timing, read-zero bits, outcome clearing and config locking of cfq_top
module cfq_top_sva
    import cfq_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [2:0]  operating_mode_field_i,
    input wire logic [1:0]  msg_outcome_i,
    input wire logic        msg_reset_i,
    input wire logic        transmit_queue_reset_i,
    input wire logic        event_timestamp_enable_o,
    input wire logic [4:0]  event_tail_o
);
    logic clr_r;
    wire  take = cyc_i & stb_i & !ack_o;
    wire  cfg_wr = take & we_i & (adr_i == CFQ_OFS_EVT_CTRL) & (operating_mode_field_i == CFQ_MODE_CONFIG);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Outcome bits known clear until the next completion or abort
    always_ff @(posedge clk_i) begin
        if (rst_i)
            clr_r <= 1'b1;
        else if (msg_outcome_i != 2'b00)
            clr_r <= 1'b0;
        else if (msg_reset_i | transmit_queue_reset_i | (take & !we_i & (adr_i == CFQ_OFS_MSG_STATUS)))
            clr_r <= 1'b1;
    end
    sequence s_rd(a);
        take && !we_i && adr_i == a;
    endsequence
    property p_ack; take |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_pulse; ack_o |=> !ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
    property p_idle; !ack_o |-> dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside ack");
    property p_ectl; s_rd(CFQ_OFS_EVT_CTRL) |=> (dat_o & 32'he0ff_fad0) == 32'h0; endproperty
    a_ectl: assert property (p_ectl) else $error("event control spare bits set");
    property p_esta; s_rd(CFQ_OFS_EVT_STATUS) |=> dat_o[31:4] == 28'h0; endproperty
    a_esta: assert property (p_esta) else $error("event status spare bits set");
    property p_msta; s_rd(CFQ_OFS_MSG_STATUS) |=> dat_o[31:13] == 19'h0; endproperty
    a_msta: assert property (p_msta) else $error("message status spare bits set");
    property p_clear; s_rd(CFQ_OFS_MSG_STATUS) ##0 clr_r |=> dat_o[7:5] == 3'b000; endproperty
    a_clear: assert property (p_clear) else $error("outcome bits not cleared");
    property p_tail; $changed(event_tail_o) |-> event_tail_o == $past(event_tail_o) + 5'h01 || event_tail_o == 5'h00;
    endproperty
    a_tail: assert property (p_tail) else $error("tail moved by more than one");
    property p_ts; $changed(event_timestamp_enable_o) |-> $past(cfg_wr) || $past(cfg_wr, 2); endproperty
    a_ts: assert property (p_ts) else $error("timestamp enable changed outside config write");
endmodule

bind cfq_top cfq_top_sva cfq_top_sva_inst (.*);

//--- bench/cfq_top_bench.sv
// Bench: register-level tests of the message and event FIFO flags
module cfq_top_bench
    import cfq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] m; logic [31:0] v;} cfq_exp_type;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, msg_irq_o, event_irq_o, ts_o, step_o;
    logic [3:0]  adr_i = 0, sel_i = 4'hf, o4 = 0;
    logic [31:0] dat_i = 0, dat_o, rd, ec, ex;
    logic [4:0]  pl = 0, tail_o, dc, t0, si;
    logic [2:0]  mode = 3'h4;
    int          failures = 0, n_tests = 0, dd, n_step = 0;
    cfq_exp_type exp_q[$], e_cur;
    cfq_top cfq_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .operating_mode_field_i(mode), .msg_push_i(pl[0]), .msg_pop_i(pl[1]), .msg_outcome_i(o4[1:0]),
        .msg_arb_lost_i(o4[3]), .msg_bus_err_i(o4[2]), .msg_reset_i(pl[2]), .transmit_queue_reset_i(pl[3]),
        .event_push_i(pl[4]), .msg_irq_o(msg_irq_o), .event_irq_o(event_irq_o),
        .event_timestamp_enable_o(ts_o), .event_tail_step_o(step_o), .event_tail_o(tail_o),
        .msg_slot_index_o(si));
    initial forever #10 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Expected read noted first; the monitor compares it when ack comes
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, m, v);
        int n;
        n = 0;
        exp_q.push_back('{m, v});
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            test_done;
        end
        rd = dat_o;
        cyc_i <= 0; stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic pulse(input logic [4:0] p, input logic [3:0] o);
        pl <= p; o4 <= o;
        @(posedge clk_i);
        pl <= 0; o4 <= 0;
        @(posedge clk_i);
    endtask
    task automatic poll;
        int k;
        k = 0;
        do wb(0, CFQ_OFS_EVT_CTRL, 0, 0, 0); while (rd[10] !== 1'b0 && ++k < 20);
        if (k >= 20) begin
            failures++;
            test_done;
        end
    endtask
    function automatic logic [2:0] mflags(input logic tx, input int c, input int d);
        if (tx) return {c == 0, 2 * c <= d, c < d};
        return {c == d, 2 * c >= d, c > 0};
    endfunction
    // Expected status after step c of the fill/drain walk: flags and slot index
    function automatic logic [31:0] mexp(input logic tx, input int c, input int d);
        int n, i;
        n = c <= d ? c : (c > 2 * d ? 0 : 2 * d + 1 - c);
        i = tx ? (c > d ? (c - d - 1 > d ? d : c - d - 1) : 0) : (c <= d ? c : d);
        i = i % d;
        return {19'h0, 5'(i), 5'h0, mflags(tx, n, d)};
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && exp_q.size() > 0) begin
            e_cur = exp_q.pop_front();
            if (e_cur.m != 0) chk(dat_o & e_cur.m, e_cur.v);
        end
    end
    always @(posedge clk_i) begin
        if (step_o === 1'b1) n_step++;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        test_done;
    end
    initial begin
        void'($urandom(47031));
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        poll();
        wb(0, CFQ_OFS_EVT_CTRL, 0, '1, 32'h0);
        wb(0, CFQ_OFS_EVT_STATUS, 0, '1, 32'h0);
        wb(0, 4'h2, 0, '1, 32'h0);
        $display("test reset values done");
        for (int t = 0; t < 2; t++) begin
            dc = 5'($urandom_range(6, 1));
            dd = dc + 1;
            wb(1, CFQ_OFS_MSG_CTRL, {3'h0, dc, 16'h0, t[0], 7'h7}, 0, 0);
            pulse(5'h04, 0);
            // Push one past full, then drain two past empty
            for (int c = 0; c <= 2 * dd + 2; c++) begin
                ex = mexp(t[0], c, dd);
                wb(0, CFQ_OFS_MSG_STATUS, 0, 32'h1f07, ex);
                chk({31'h0, msg_irq_o}, {31'h0, |ex[2:0]});
                chk({27'h0, si}, {27'h0, ex[12:8]});
                pulse(c <= dd ? 5'h01 : 5'h02, 0);
            end
            $display("test message flags direction %0d done", t);
        end
        wb(0, CFQ_OFS_MSG_STATUS, 0, 0, 0);
        pulse(0, 4'ha);
        wb(0, CFQ_OFS_MSG_STATUS, 0, 32'he0, 32'hc0);
        wb(0, CFQ_OFS_MSG_STATUS, 0, 32'he0, 32'h0);
        pulse(0, 4'h5);
        wb(0, CFQ_OFS_MSG_STATUS, 0, 32'he0, 32'h20);
        pulse(0, 4'h5);
        pulse(5'h08, 0);
        wb(0, CFQ_OFS_MSG_STATUS, 0, 32'he0, 32'h0);
        pulse(0, 4'hc);
        wb(0, CFQ_OFS_MSG_STATUS, 0, 32'he0, 32'h0);
        $display("test outcome bits done");
        dc = 5'($urandom_range(3, 1));
        dd = dc + 1;
        ec = {3'h0, dc, 24'h2f};
        wb(1, CFQ_OFS_EVT_CTRL, ec, 0, 0);
        wb(0, CFQ_OFS_EVT_CTRL, 0, '1, ec);
        chk({31'h0, ts_o}, 32'h1);
        for (int c = 0; c <= dd; c++) begin
            wb(0, CFQ_OFS_EVT_STATUS, 0, '1, {29'h0, c == dd, 2 * c >= dd, c > 0});
            chk({31'h0, event_irq_o}, {31'h0, c > 0});
            pulse(5'h10, 0);
        end
        wb(0, CFQ_OFS_EVT_STATUS, 0, '1, 32'hf);
        wb(1, CFQ_OFS_EVT_STATUS, 0, 0, 0);
        wb(0, CFQ_OFS_EVT_STATUS, 0, '1, 32'h7);
        t0 = tail_o;
        wb(1, CFQ_OFS_EVT_CTRL, ec | 32'h100, 0, 0);
        wb(0, CFQ_OFS_EVT_STATUS, 0, '1, {30'h0, 2 * (dd - 1) >= dd, 1'b1});
        chk({27'h0, tail_o}, {27'h0, t0 + 5'h01});
        chk(32'(n_step), 32'h1);
        pulse(5'h10, 0);
        pulse(5'h10, 0);
        wb(1, CFQ_OFS_EVT_CTRL, ec | 32'h400, 0, 0);
        poll();
        wb(0, CFQ_OFS_EVT_STATUS, 0, '1, 32'h0);
        mode <= 3'h0;
        wb(1, CFQ_OFS_EVT_CTRL, {3'h0, ~dc, 24'h00}, 0, 0);
        wb(0, CFQ_OFS_EVT_CTRL, 0, '1, {3'h0, dc, 24'h20});
        mode <= 3'h4;
        $display("test event fifo done");
        test_done;
    end
endmodule
